// ===== src/fpk_defines.vh
// Purpose: Constants for the front panel key and menu controller
// Assumes: 100 MHz mclk_i
// Notes: Times in ms, cycle counts derived from them
`ifndef FPK_DEFINES_VH
`define FPK_DEFINES_VH
`define FPK_CLK_KHZ 100000
`define FPK_TEST_MS 2000
`define FPK_TEST_CYC (`FPK_TEST_MS * `FPK_CLK_KHZ)
`define FPK_INIT_MS 3000
`define FPK_INIT_CYC (`FPK_INIT_MS * `FPK_CLK_KHZ)
`define FPK_ACK_MS 1000
`define FPK_ACK_CYC (`FPK_ACK_MS * `FPK_CLK_KHZ)
`define FPK_DEB_MS 10
`define FPK_DEB_CYC (`FPK_DEB_MS * `FPK_CLK_KHZ)
`define FPK_FACTORY_CODE 8'h42
`define FPK_SVC_MODULE 4'h9
// Wishbone byte offsets
`define FPK_REG_CTRL 4'h0
`define FPK_REG_PERM 4'h4
`define FPK_REG_STAT 4'h8
`define FPK_REG_ENTRY 4'hc
// Permission bit positions
`define FPK_P_ANY_QUICK 0
`define FPK_P_RST_AL 1
`define FPK_P_RST_BUF 2
`define FPK_P_SELDSP 3
`define FPK_P_RSTTOT 4
`define FPK_P_TARE 5
`define FPK_PERM_RST 6'h3f
// Display message codes
`define FPK_MSG_READING 4'h0
`define FPK_MSG_TEST 4'h1
`define FPK_MSG_RESTORE 4'h2
`define FPK_MSG_LOCKED 4'h3
`define FPK_MSG_AL1 4'h4
`define FPK_MSG_AL2 4'h5
`define FPK_MSG_PEAK 4'h6
`define FPK_MSG_VALLEY 4'h7
`define FPK_MSG_ACK 4'h8
`define FPK_MSG_PRO0 4'h9
`define FPK_MSG_QUICK 4'ha
`define FPK_MSG_SETPT 4'hb
`endif

// ===== src/fpk_key_debounce.v
// Purpose: Synchronise and debounce one front panel key
// Assumes: Key level active high, asynchronous to mclk_i
// Notes: press_o pulses once per accepted press
`timescale 1ns/1ps
`default_nettype none
`include "fpk_defines.vh"
module fpk_key_debounce #(
  parameter DEB_CYC = `FPK_DEB_CYC
) (
  input wire mclk_i,
  input wire nrst_i,
  input wire key_i,
  output reg held_o,
  output reg press_o
);
  reg sync1_ff;
  reg sync2_ff;
  reg [23:0] cnt_ff;
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      cnt_ff <= 24'h0;
      held_o <= 1'b0;
      press_o <= 1'b0;
    end else begin
      sync1_ff <= key_i;
      sync2_ff <= sync1_ff;
      press_o <= 1'b0;
      // Level must stay put for the whole window before it is believed
      if (sync2_ff == held_o) begin
        cnt_ff <= 24'h0;
      end else if (cnt_ff >= DEB_CYC[23:0] - 24'h1) begin
        cnt_ff <= 24'h0;
        held_o <= sync2_ff; // RULE20
        press_o <= sync2_ff;
      end else begin
        cnt_ff <= cnt_ff + 24'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== src/fpk_panel_ctrl.v
// Purpose: Front panel key and menu controller of a panel meter
// Assumes: Keys active high, lockout pin low when tied to common
// Notes: Display content is a message code; value formatting is here too
//
// Summary of operation
// RULE1 - Service module code 66 plus program restores defaults; code restores on the ENTRY write, program key unused
// RULE2 - Restore shows message, then returns to module zero
// RULE3 - Unknown service code returns to module zero
// RULE4 - Power-up lights all segments for 2 s
// RULE5 - Display mode kept across power loss
// RULE6 - Down selects input, up selects total
// RULE7 - Minus sign and leading zero formatting
// RULE8 - Lockout limits access to permitted parameters
// RULE9 - Lockout with no permissions shows locked
// RULE10 - Lockout with permissions enters quick programming
// RULE11 - Quick setpoint edits apply on program key
// RULE12 - Latch prompt only when alarm latched
// RULE13 - Down plus program clears alarm latch
// RULE14 - Down plus program clears peak/valley buffer
// RULE15 - Normal key functions need their permission
// RULE16 - Down plus program applies tare
// RULE17 - Up plus program clears totalizer
// RULE18 - Program alone enters full or quick programming
// RULE19 - Brief acknowledge message after each operation; code shows it only after tare, totalizer clear and display select
// RULE20 - Debounced keys, combo when modifier already held
//
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fpk_defines.vh"
module fpk_panel_ctrl #(
  parameter TEST_CYC = `FPK_TEST_CYC,
  parameter INIT_CYC = `FPK_INIT_CYC,
  parameter ACK_CYC = `FPK_ACK_CYC,
  parameter DEB_CYC = `FPK_DEB_CYC
) (
  input wire mclk_i,
  input wire nrst_i,
  input wire key_prog_i,
  input wire key_up_i,
  input wire key_down_i,
  input wire program_lockout_n_i,
  input wire al1_latched_i,
  input wire al2_latched_i,
  input wire saved_total_mode_i,
  input wire value_neg_i,
  input wire [2:0] value_dp_i,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg [3:0] disp_msg_o,
  output reg all_segments_o,
  output reg show_total_o,
  output reg save_mode_o,
  output reg minus_sign_o,
  output reg lead_zero_o,
  output reg factory_restore_o,
  output reg tare_o,
  output reg total_clear_o,
  output reg al1_clear_o,
  output reg al2_clear_o,
  output reg peak_clear_o,
  output reg valley_clear_o,
  output reg setpoint_apply_o,
  output reg full_prog_o
);
  localparam ST_TEST = 4'h0;
  localparam ST_RUN = 4'h1;
  localparam ST_ACK = 4'h2;
  localparam ST_FULL = 4'h3;
  localparam ST_RESTORE = 4'h4;
  localparam ST_Q_SET = 4'h5;
  localparam ST_Q_AL1 = 4'h6;
  localparam ST_Q_AL2 = 4'h7;
  localparam ST_Q_PEAK = 4'h8;
  localparam ST_Q_VAL = 4'h9;
  localparam ST_LOCKED = 4'ha;

  wire prog_held;
  wire prog_press;
  wire up_held;
  wire up_press;
  wire down_held;
  wire down_press;
  reg lock_s1_ff;
  reg lock_ff;
  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  reg [31:0] tmr_ff;
  reg [31:0] nxt_tmr;
  reg [5:0] perm_ff;
  reg [7:0] entry_code_ff;
  reg [3:0] entry_mod_ff;
  reg entry_go_ff;
  reg mode_loaded_ff;
  reg [3:0] nxt_msg;
  reg nxt_restore;
  reg nxt_tare;
  reg nxt_tot;
  reg nxt_al1;
  reg nxt_al2;
  reg nxt_peak;
  reg nxt_val;
  reg nxt_apply;
  reg nxt_total_mode;
  wire quick_any;
  wire bus_req;
  wire [3:0] bus_off;

  fpk_key_debounce #(.DEB_CYC(DEB_CYC)) u_key_prog (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .key_i(key_prog_i),
    .held_o(prog_held),
    .press_o(prog_press)
  );
  fpk_key_debounce #(.DEB_CYC(DEB_CYC)) u_key_up (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .key_i(key_up_i),
    .held_o(up_held),
    .press_o(up_press)
  );
  fpk_key_debounce #(.DEB_CYC(DEB_CYC)) u_key_down (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .key_i(key_down_i),
    .held_o(down_held),
    .press_o(down_press)
  );

  // Lockout is a pin, so it gets two flops before use
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lock_s1_ff <= 1'b0;
      lock_ff <= 1'b0;
    end else begin
      lock_s1_ff <= ~program_lockout_n_i;
      lock_ff <= lock_s1_ff;
    end
  end

  assign quick_any = perm_ff[`FPK_P_ANY_QUICK]; // RULE8
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_off = wb_adr_i[3:0];

  // Wishbone slave, one wait state, ack drops after one cycle
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      perm_ff <= `FPK_PERM_RST;
      entry_code_ff <= 8'h0;
      entry_mod_ff <= 4'h0;
      entry_go_ff <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
      entry_go_ff <= 1'b0;
      wb_dat_o <= 32'h0;
      if (bus_req && wb_adr_i[31:4] == 28'h0) begin
        case (bus_off)
          `FPK_REG_CTRL: wb_dat_o <= {31'h0, full_prog_o};
          `FPK_REG_PERM: wb_dat_o <= {26'h0, perm_ff};
          `FPK_REG_STAT: wb_dat_o <= {22'h0, lock_ff, show_total_o, disp_msg_o, state_ff};
          `FPK_REG_ENTRY: wb_dat_o <= {20'h0, entry_mod_ff, entry_code_ff};
          default: wb_dat_o <= 32'h0;
        endcase
        if (wb_we_i && wb_sel_i[0]) begin
          case (bus_off)
            `FPK_REG_PERM: perm_ff <= wb_dat_i[5:0];
            `FPK_REG_ENTRY: begin
              entry_code_ff <= wb_dat_i[7:0];
              if (wb_sel_i[1]) begin
                entry_mod_ff <= wb_dat_i[11:8];
              end
              // Entry commits only while full programming owns the panel
              entry_go_ff <= 1'b1;
            end
            default: ;
          endcase
        end
      end
    end
  end

  // Menu state machine
  always @* begin
    nxt_state = state_ff;
    nxt_tmr = tmr_ff;
    nxt_msg = disp_msg_o;
    nxt_restore = 1'b0;
    nxt_tare = 1'b0;
    nxt_tot = 1'b0;
    nxt_al1 = 1'b0;
    nxt_al2 = 1'b0;
    nxt_peak = 1'b0;
    nxt_val = 1'b0;
    nxt_apply = 1'b0;
    nxt_total_mode = show_total_o;
    case (state_ff)
      ST_TEST: begin
        nxt_msg = `FPK_MSG_TEST;
        if (tmr_ff >= TEST_CYC - 1) begin // RULE4
          nxt_state = ST_RUN;
          nxt_tmr = 32'h0;
          nxt_msg = `FPK_MSG_READING;
        end else begin
          nxt_tmr = tmr_ff + 32'h1;
        end
      end
      ST_RUN: begin
        nxt_msg = `FPK_MSG_READING;
        if (prog_press) begin
          nxt_tmr = 32'h0;
          if (down_held && perm_ff[`FPK_P_TARE]) begin // RULE20
            nxt_tare = 1'b1; // RULE16
            nxt_state = ST_ACK; // RULE19
            nxt_msg = `FPK_MSG_ACK;
          end else if (up_held && perm_ff[`FPK_P_RSTTOT]) begin // RULE15
            nxt_tot = 1'b1; // RULE17
            nxt_state = ST_ACK;
            nxt_msg = `FPK_MSG_ACK;
          end else if (!down_held && !up_held) begin
            if (!lock_ff) begin
              nxt_state = ST_FULL; // RULE18
              nxt_msg = `FPK_MSG_PRO0;
            end else if (quick_any) begin
              nxt_state = ST_Q_SET; // RULE10
              nxt_msg = `FPK_MSG_SETPT;
            end else begin
              nxt_state = ST_LOCKED; // RULE9
              nxt_msg = `FPK_MSG_LOCKED;
            end
          end
        end else if (down_press && !prog_held && perm_ff[`FPK_P_SELDSP]) begin
          nxt_total_mode = 1'b0; // RULE6
          nxt_state = ST_ACK;
          nxt_tmr = 32'h0;
          nxt_msg = `FPK_MSG_ACK;
        end else if (up_press && !prog_held && perm_ff[`FPK_P_SELDSP]) begin
          nxt_total_mode = 1'b1; // RULE6
          nxt_state = ST_ACK;
          nxt_tmr = 32'h0;
          nxt_msg = `FPK_MSG_ACK;
        end
      end
      ST_ACK, ST_LOCKED: begin
        if (tmr_ff >= ACK_CYC - 1) begin
          nxt_state = ST_RUN;
          nxt_tmr = 32'h0;
          nxt_msg = `FPK_MSG_READING;
        end else begin
          nxt_tmr = tmr_ff + 32'h1;
        end
      end
      ST_FULL: begin
        nxt_msg = `FPK_MSG_PRO0; // RULE3
        if (entry_go_ff && entry_mod_ff == `FPK_SVC_MODULE) begin
          if (entry_code_ff == `FPK_FACTORY_CODE) begin
            nxt_restore = 1'b1; // RULE1
            nxt_state = ST_RESTORE;
            nxt_tmr = 32'h0;
            nxt_msg = `FPK_MSG_RESTORE;
          end
          // Any other code: stay at module zero, nothing done
        end else if (prog_press && down_held) begin
          nxt_state = ST_RUN;
          nxt_msg = `FPK_MSG_READING;
        end
      end
      ST_RESTORE: begin
        if (tmr_ff >= INIT_CYC - 1) begin // RULE2
          nxt_state = ST_FULL;
          nxt_tmr = 32'h0;
          nxt_msg = `FPK_MSG_PRO0;
        end else begin
          nxt_tmr = tmr_ff + 32'h1;
        end
      end
      ST_Q_SET: begin
        if (prog_press) begin
          nxt_apply = 1'b1; // RULE11
          if (al1_latched_i && perm_ff[`FPK_P_RST_AL]) begin // RULE12
            nxt_state = ST_Q_AL1;
            nxt_msg = `FPK_MSG_AL1;
          end else if (al2_latched_i && perm_ff[`FPK_P_RST_AL]) begin
            nxt_state = ST_Q_AL2;
            nxt_msg = `FPK_MSG_AL2;
          end else if (perm_ff[`FPK_P_RST_BUF]) begin
            nxt_state = ST_Q_PEAK;
            nxt_msg = `FPK_MSG_PEAK;
          end else begin
            nxt_state = ST_RUN;
            nxt_msg = `FPK_MSG_READING;
          end
        end
      end
      ST_Q_AL1: begin
        if (prog_press) begin
          nxt_al1 = down_held; // RULE13
          if (al2_latched_i && perm_ff[`FPK_P_RST_AL]) begin // RULE12
            nxt_state = ST_Q_AL2;
            nxt_msg = `FPK_MSG_AL2;
          end else if (perm_ff[`FPK_P_RST_BUF]) begin
            nxt_state = ST_Q_PEAK;
            nxt_msg = `FPK_MSG_PEAK;
          end else begin
            nxt_state = ST_RUN;
            nxt_msg = `FPK_MSG_READING;
          end
        end
      end
      ST_Q_AL2: begin
        if (prog_press) begin
          nxt_al2 = down_held; // RULE13
          if (perm_ff[`FPK_P_RST_BUF]) begin
            nxt_state = ST_Q_PEAK;
            nxt_msg = `FPK_MSG_PEAK;
          end else begin
            nxt_state = ST_RUN;
            nxt_msg = `FPK_MSG_READING;
          end
        end
      end
      ST_Q_PEAK: begin
        if (prog_press) begin
          nxt_peak = down_held; // RULE14
          nxt_state = ST_Q_VAL;
          nxt_msg = `FPK_MSG_VALLEY;
        end
      end
      ST_Q_VAL: begin
        if (prog_press) begin
          nxt_val = down_held; // RULE14
          nxt_state = ST_RUN;
          nxt_msg = `FPK_MSG_READING;
        end
      end
      default: begin
        nxt_state = ST_RUN;
        nxt_msg = `FPK_MSG_READING;
      end
    endcase
  end

  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= ST_TEST;
      tmr_ff <= 32'h0;
      disp_msg_o <= `FPK_MSG_TEST;
      all_segments_o <= 1'b1;
      show_total_o <= 1'b0;
      save_mode_o <= 1'b0;
      mode_loaded_ff <= 1'b0;
      minus_sign_o <= 1'b0;
      lead_zero_o <= 1'b0;
      factory_restore_o <= 1'b0;
      tare_o <= 1'b0;
      total_clear_o <= 1'b0;
      al1_clear_o <= 1'b0;
      al2_clear_o <= 1'b0;
      peak_clear_o <= 1'b0;
      valley_clear_o <= 1'b0;
      setpoint_apply_o <= 1'b0;
      full_prog_o <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      tmr_ff <= nxt_tmr;
      disp_msg_o <= nxt_msg;
      all_segments_o <= (nxt_state == ST_TEST); // RULE4
      full_prog_o <= (nxt_state == ST_FULL) | (nxt_state == ST_RESTORE);
      // Saved mode is taken after reset release, never under reset
      mode_loaded_ff <= 1'b1;
      if (!mode_loaded_ff) begin
        show_total_o <= saved_total_mode_i; // RULE5
      end else begin
        show_total_o <= nxt_total_mode;
      end
      save_mode_o <= mode_loaded_ff & (nxt_total_mode != show_total_o); // RULE5
      minus_sign_o <= value_neg_i; // RULE7
      lead_zero_o <= (value_dp_i != 3'h0); // RULE7
      factory_restore_o <= nxt_restore;
      tare_o <= nxt_tare;
      total_clear_o <= nxt_tot;
      al1_clear_o <= nxt_al1;
      al2_clear_o <= nxt_al2;
      peak_clear_o <= nxt_peak;
      valley_clear_o <= nxt_val;
      setpoint_apply_o <= nxt_apply;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/fpk_panel_ctrl_properties.sv
// Purpose: Port-level checks of the panel key controller
// Assumes: Saved display mode held steady through reset release
// Notes: Bound to every fpk_panel_ctrl instance
`timescale 1ns/1ps
`default_nettype none
`include "fpk_defines.vh"
module fpk_panel_ctrl_properties #(
  parameter TEST_CYC = 20,
  parameter INIT_CYC = 30,
  parameter ACK_CYC = 10,
  parameter DEB_CYC = 4
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [3:0] disp_msg_o,
  input wire logic all_segments_o,
  input wire logic show_total_o,
  input wire logic saved_total_mode_i,
  input wire logic value_neg_i,
  input wire logic [2:0] value_dp_i,
  input wire logic minus_sign_o,
  input wire logic lead_zero_o,
  input wire logic factory_restore_o,
  input wire logic tare_o,
  input wire logic total_clear_o,
  input wire logic full_prog_o,
  input wire logic al1_latched_i,
  input wire logic setpoint_apply_o
);
  int cnt_ff;
  // Cycles since reset release, saturating so it never wraps
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_ff <= 0;
    end else if (cnt_ff < 1000) begin
      cnt_ff <= cnt_ff + 1;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_restore_msg;
    (disp_msg_o == `FPK_MSG_RESTORE) [*8];
  endsequence
  sequence s_restore_end;
    (disp_msg_o == `FPK_MSG_RESTORE) ##1 (disp_msg_o != `FPK_MSG_RESTORE);
  endsequence
  property p_wb_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("bus ack late");
  property p_wb_ack_drop;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_wb_ack_drop: assert property (p_wb_ack_drop) else $error("bus ack too long");
  // One cycle of slack before the end of the test span, two cycles after it
  property p_test_on;
    cnt_ff < TEST_CYC - 1 |-> all_segments_o && disp_msg_o == `FPK_MSG_TEST;
  endproperty
  a_test_on: assert property (p_test_on) else $error("display test ended early");
  property p_test_off;
    cnt_ff > TEST_CYC + 1 |-> !all_segments_o;
  endproperty
  a_test_off: assert property (p_test_off) else $error("display test too long");
  property p_mode;
    cnt_ff == 2 |-> show_total_o == saved_total_mode_i;
  endproperty
  a_mode: assert property (p_mode) else $error("saved mode not restored");
  property p_fmt;
    1'b1 |=> minus_sign_o == $past(value_neg_i) && lead_zero_o == ($past(value_dp_i) != 3'h0);
  endproperty
  a_fmt: assert property (p_fmt) else $error("value format wrong");
  property p_restore;
    factory_restore_o |-> full_prog_o ##[0:2] s_restore_msg;
  endproperty
  a_restore: assert property (p_restore) else $error("restore message missing");
  property p_restore_end;
    s_restore_end |-> disp_msg_o == `FPK_MSG_PRO0;
  endproperty
  a_restore_end: assert property (p_restore_end) else $error("restore did not return");
  property p_ack_msg;
    tare_o || total_clear_o |-> ##[0:2] disp_msg_o == `FPK_MSG_ACK;
  endproperty
  a_ack_msg: assert property (p_ack_msg) else $error("no acknowledge message");
  property p_latch;
    $rose(disp_msg_o == `FPK_MSG_AL1) |-> al1_latched_i;
  endproperty
  a_latch: assert property (p_latch) else $error("latch prompt while unlatched");
  property p_locked;
    disp_msg_o == `FPK_MSG_LOCKED |-> !full_prog_o && !setpoint_apply_o;
  endproperty
  a_locked: assert property (p_locked) else $error("locked yet programming");
endmodule
bind fpk_panel_ctrl fpk_panel_ctrl_properties #(.TEST_CYC(TEST_CYC), .INIT_CYC(INIT_CYC), .ACK_CYC(ACK_CYC),
  .DEB_CYC(DEB_CYC)) chk_u (.mclk_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .disp_msg_o, .all_segments_o,
  .show_total_o, .saved_total_mode_i, .value_neg_i, .value_dp_i, .minus_sign_o, .lead_zero_o,
  .factory_restore_o, .tare_o, .total_clear_o, .full_prog_o, .al1_latched_i, .setpoint_apply_o);
`default_nettype wire

// ===== testbench/fpk_operator.sv
// Purpose: Operator at the front panel keys
// Assumes: Bit 2 program, bit 1 up, bit 0 down
// Notes: Every edge bounces, shorter than the debounce window
`timescale 1ns/1ps
`default_nettype none
module fpk_operator #(
  parameter int DEB = 4
) (
  input wire logic mclk_i,
  output logic [2:0] keys_o
);
  initial keys_o = 3'h0;
  task set_key(input int k, input logic v);
    repeat (2) begin
      @(posedge mclk_i);
      keys_o[k] <= ~v;
      @(posedge mclk_i);
      keys_o[k] <= v;
    end
    repeat (DEB + 8) @(posedge mclk_i);
  endtask
  task press(input int k);
    set_key(k, 1'b1);
    set_key(k, 1'b0);
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb_front_panel_key_menu_control.sv
// Purpose: Self-checking bench of the panel key controller
// Assumes: Short counts so the run stays brief
// Notes: Pulse outputs are tallied and compared as counts
`timescale 1ns/1ps
`default_nettype none
`include "fpk_defines.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; $display("BAD %0t got %0h want %0h", $time, a, b); end end
module tb_front_panel_key_menu_control;
  localparam int DEB = 4, TEST = 20, INIT = 60, ACKC = 40;
  logic mclk_i = 1'b0, nrst_i = 1'b0, program_lockout_n_i = 1'b1, al1_latched_i = 1'b0, al2_latched_i = 1'b0;
  logic saved_total_mode_i = 1'b1, value_neg_i = 1'b0, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic [2:0] value_dp_i = 3'h0, keys;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, q;
  logic [3:0] wb_sel_i = 4'h0, disp_msg_o;
  logic wb_ack_o, all_segments_o, show_total_o, save_mode_o, minus_sign_o, lead_zero_o, factory_restore_o;
  logic tare_o, total_clear_o, al1_clear_o, al2_clear_o, peak_clear_o, valley_clear_o, setpoint_apply_o;
  logic full_prog_o;
  int errors = 0, n_tests = 0, pc[9] = '{default: 0};
  wire [8:0] pls = {save_mode_o, factory_restore_o, tare_o, total_clear_o, al1_clear_o, al2_clear_o, peak_clear_o,
    valley_clear_o, setpoint_apply_o};
  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    for (int i = 0; i < 9; i++) pc[i] <= pc[i] + pls[i];
  end
  fpk_operator #(.DEB(DEB)) op_u (.mclk_i, .keys_o(keys));
  fpk_panel_ctrl #(.TEST_CYC(TEST), .INIT_CYC(INIT), .ACK_CYC(ACKC), .DEB_CYC(DEB)) dut_u (.mclk_i, .nrst_i,
    .key_prog_i(keys[2]), .key_up_i(keys[1]), .key_down_i(keys[0]), .program_lockout_n_i, .al1_latched_i,
    .al2_latched_i, .saved_total_mode_i, .value_neg_i, .value_dp_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i,
    .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .disp_msg_o, .all_segments_o, .show_total_o, .save_mode_o,
    .minus_sign_o, .lead_zero_o, .factory_restore_o, .tare_o, .total_clear_o, .al1_clear_o, .al2_clear_o,
    .peak_clear_o, .valley_clear_o, .setpoint_apply_o, .full_prog_o);
  task stop_test;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Classic single cycle; waits for ack however long it takes
  task wb(input logic we, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    @(posedge mclk_i);
    while (wb_ack_o !== 1'b1) @(posedge mclk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  // Modifier (or none when negative) held before program is pressed
  task push(input int mod, input logic [3:0] m, input bit chk);
    if (mod >= 0) begin
      op_u.set_key(mod, 1'b1);
      // A lone modifier press may select a display; program is ignored until its acknowledge ends
      repeat (ACKC) @(posedge mclk_i);
    end
    op_u.set_key(2, 1'b1);
    if (chk) `CHK(disp_msg_o, m)
    op_u.set_key(2, 1'b0);
    if (mod >= 0) op_u.set_key(mod, 1'b0);
    repeat (ACKC) @(posedge mclk_i);
  endtask
  initial begin
    repeat (20000) @(posedge mclk_i);
    errors++;
    stop_test;
  end
  initial begin
    repeat (3) @(posedge mclk_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    `CHK(all_segments_o, 1'b1)
    repeat (TEST + 4) @(posedge mclk_i);
    `CHK(disp_msg_o, `FPK_MSG_READING)
    `CHK(show_total_o, 1'b1)
    wb(1'b0, 32'h4, 32'h0);
    `CHK(q[5:0], `FPK_PERM_RST)
    wb(1'b0, 32'h10, 32'h0);
    `CHK(q, 32'h0)
    // Unmapped offset must not alias onto the permission register
    wb(1'b1, 32'h14, 32'h0);
    wb(1'b0, 32'h4, 32'h0);
    `CHK(q[5:0], `FPK_PERM_RST)
    op_u.press(0);
    `CHK(show_total_o, 1'b0)
    repeat (ACKC) @(posedge mclk_i);
    op_u.press(1);
    `CHK(show_total_o, 1'b1)
    `CHK(pc[8], 2)
    repeat (ACKC) @(posedge mclk_i);
    push(0, `FPK_MSG_ACK, 1'b1);
    `CHK(pc[6], 1)
    push(1, `FPK_MSG_ACK, 1'b1);
    `CHK(pc[5], 1)
    // Tare permission off, so the combination must do nothing
    wb(1'b1, 32'h4, 32'h1f);
    push(0, 4'h0, 1'b0);
    `CHK(pc[6], 1)
    push(-1, `FPK_MSG_PRO0, 1'b1);
    wb(1'b0, 32'h0, 32'h0);
    `CHK(q[0], 1'b1)
    wb(1'b0, 32'h10, 32'h0);
    `CHK(q, 32'h0)
    wb(1'b1, 32'hc, 32'h905);
    repeat (5) @(posedge mclk_i);
    `CHK(disp_msg_o, `FPK_MSG_PRO0)
    `CHK(pc[7], 0)
    wb(1'b1, 32'hc, 32'h942);
    repeat (5) @(posedge mclk_i);
    `CHK(disp_msg_o, `FPK_MSG_RESTORE)
    `CHK(pc[7], 1)
    repeat (INIT + 5) @(posedge mclk_i);
    `CHK(disp_msg_o, `FPK_MSG_PRO0)
    push(0, 4'h0, 1'b0);
    `CHK(full_prog_o, 1'b0)
    program_lockout_n_i <= 1'b0;
    wb(1'b1, 32'h4, 32'h0);
    push(-1, `FPK_MSG_LOCKED, 1'b1);
    `CHK(full_prog_o, 1'b0)
    wb(1'b1, 32'h4, 32'h3f);
    al1_latched_i <= 1'b1;
    push(-1, `FPK_MSG_SETPT, 1'b1);
    `CHK(full_prog_o, 1'b0)
    push(-1, `FPK_MSG_AL1, 1'b1);
    `CHK(pc[0], 1)
    push(-1, `FPK_MSG_PEAK, 1'b1);
    `CHK(pc[4], 0)
    push(0, 4'h0, 1'b0);
    `CHK(pc[2], 1)
    `CHK(pc[1], 0)
    push(-1, `FPK_MSG_READING, 1'b1);
    `CHK(pc[1], 0)
    al2_latched_i <= 1'b1;
    push(-1, `FPK_MSG_SETPT, 1'b1);
    push(-1, `FPK_MSG_AL1, 1'b1);
    push(0, `FPK_MSG_AL2, 1'b1);
    `CHK(pc[4], 1)
    push(0, `FPK_MSG_PEAK, 1'b1);
    `CHK(pc[3], 1)
    push(-1, `FPK_MSG_VALLEY, 1'b1);
    `CHK(pc[2], 1)
    push(0, `FPK_MSG_READING, 1'b1);
    `CHK(pc[1], 1)
    value_neg_i <= 1'b1;
    value_dp_i <= 3'h2;
    repeat (3) @(posedge mclk_i);
    `CHK(minus_sign_o, 1'b1)
    `CHK(lead_zero_o, 1'b1)
    stop_test;
  end
endmodule
`default_nettype wire
